// File: fscr_regs.sv
// Status and configuration register logic of the serial flash.
`timescale 1ns/10ps
`default_nettype none
module fscr_regs #(
   parameter int PPE_CYCLES = fscr_pkg::PPE_WRITE_CYCLES
) (
   // Clock and synchronous reset (power-up).
   input wire logic clk,
   input wire logic resetn,
   // Decoded command from the instruction decoder.
   input wire logic cmdValid,
   input wire fscr_pkg::fscr_cmd_t cmdKind,
   input wire logic [15:0] cmdData,
   input wire logic quadMode,
   // Array engine handshake.
   input wire logic engineDone,
   output logic engineStart,
   output logic engineSuspend,
   output logic engineResume,
   // Pins and non-volatile store.
   input wire logic writeProtectN,
   input wire logic nvProtectPinEnable,
   input wire logic nvPermLocked,
   input wire logic nvSecLocked,
   output logic nvPpeWrite,
   output logic nvPpeValue,
   // Side effects toward protection logic.
   output logic bprWrite,
   output logic permLockWrite,
   output logic protectPinsActive,
   output logic quadLinesActive,
   output logic hwWriteProtect,
   // Register contents and command outcome.
   output logic [7:0] flash_status,
   output logic [7:0] flash_configuration,
   output logic cmdAccepted,
   output logic cmdRejected
);

   localparam int CW = $clog2(PPE_CYCLES + 1);
   localparam logic [CW-1:0] PPE_LOAD = CW'(PPE_CYCLES - 1);
   localparam logic [CW-1:0] CNT_ZERO = '0;

   fscr_pkg::fscr_op_t opState_q, opState_d;
   logic write_enable_latch_q, write_enable_latch_d;
   logic erase_suspended_flag_q, erase_suspended_flag_d;
   logic program_suspended_flag_q, program_suspended_flag_d;
   logic protection_lockdown_flag_q;
   logic secLocked_q;
   logic permLocked_q;
   logic pin_function_select_q;
   logic protect_pin_enable_q;
   logic ppePending_q;
   logic [CW-1:0] ppeCnt_q;
   logic accepted_q, rejected_q;
   logic start_q, suspend_q, resume_q, bpr_q, perm_q, nvw_q;

   // Command class decode.
   wire isWren = cmdKind == fscr_pkg::CMD_WRITE_ENABLE;
   wire isWrdi = cmdKind == fscr_pkg::CMD_WRITE_DISABLE;
   wire isWrsr = cmdKind == fscr_pkg::CMD_WRITE_STATUS;
   wire isProg = cmdKind == fscr_pkg::CMD_PAGE_PROGRAM;
   wire isQpp = cmdKind == fscr_pkg::CMD_QUAD_PAGE_PROGRAM;
   wire isErase = cmdKind == fscr_pkg::CMD_ERASE;
   wire isWbpr = cmdKind == fscr_pkg::CMD_WRITE_BLOCK_PROTECT;
   wire isLbpr = cmdKind == fscr_pkg::CMD_LOCKDOWN_BLOCK_PROTECT;
   wire isPerm = cmdKind == fscr_pkg::CMD_WRITE_PERMANENT_LOCK;
   wire isPsid = cmdKind == fscr_pkg::CMD_PROGRAM_SECURITY;
   wire isLsid = cmdKind == fscr_pkg::CMD_LOCKOUT_SECURITY;
   wire isSusp = cmdKind == fscr_pkg::CMD_SUSPEND;
   wire isRes = cmdKind == fscr_pkg::CMD_RESUME;
   wire isRst = cmdKind == fscr_pkg::CMD_RESET;
   wire isQuad = isQpp || cmdKind == fscr_pkg::CMD_QUAD_OUTPUT_READ ||
      cmdKind == fscr_pkg::CMD_QUAD_IO_READ ||
      cmdKind == fscr_pkg::CMD_WRAPPED_BURST_READ;
   wire isProgKind = isProg || isQpp || isPsid || isLsid;
   wire isEngine = isProgKind || isErase;
   wire needsWel = isEngine || isWbpr || isLbpr || isPerm || isWrsr;

   // Operation state views.
   wire busy = opState_q != fscr_pkg::OP_IDLE; // [R1]
   wire inProg = opState_q == fscr_pkg::OP_PROGRAM;
   wire inErase = opState_q == fscr_pkg::OP_ERASE;
   wire opDone = engineDone && (inProg || inErase);
   wire ppeDone = opState_q == fscr_pkg::OP_PPE_WRITE &&
      ppeCnt_q == CNT_ZERO;

   // Pin function applies only outside four-bit command mode.
   wire pinFuncEff = pin_function_select_q && !quadMode; // [R12]
   wire hwProtect = !writeProtectN && protect_pin_enable_q &&
      !pin_function_select_q && !quadMode; // [R15] [R18]

   // Write-status config byte and whether it changes the enable.
   wire [7:0] newCfg = cmdData[fscr_pkg::WRSR_CFG_LSB +: 8];
   wire ppeChange = newCfg[fscr_pkg::CFG_PROTECT_PIN_EN] !=
      protect_pin_enable_q;

   // Rejection reasons.
   wire noWel = needsWel && !write_enable_latch_q; // [R3]
   wire busyBlock = needsWel && busy;
   wire protBlock = hwProtect && (isWbpr || isWrsr); // [R17]
   wire lockBlock = protection_lockdown_flag_q && (isWbpr || isPerm);
   wire quadBlock = isQuad && !pin_function_select_q && !quadMode; // [R11]
   wire secBlock = secLocked_q && (isPsid || isLsid);
   wire suspBlock = (isProgKind && program_suspended_flag_q) ||
      (isErase && (erase_suspended_flag_q || program_suspended_flag_q));
   wire suspNoOp = isSusp && !(inProg || inErase);
   wire resNoOp = isRes && (busy ||
      !(erase_suspended_flag_q || program_suspended_flag_q));
   wire reject = noWel || busyBlock || protBlock || lockBlock ||
      quadBlock || secBlock || suspBlock || suspNoOp || resNoOp;
   wire accept = cmdValid && !reject;

   // Accepted command events.
   wire goProg = accept && isProgKind;
   wire goErase = accept && isErase;
   wire goWrsr = accept && isWrsr;
   wire goPpe = goWrsr && ppeChange; // [R16]
   wire goSusp = accept && isSusp;
   wire goResProg = accept && isRes && program_suspended_flag_q;
   wire goResErase = accept && isRes && !program_suspended_flag_q;

   // Operation sequencer.
   always_comb begin
      opState_d = opState_q;
      case (opState_q)
         fscr_pkg::OP_IDLE: begin
            if (goProg || goResProg) begin
               opState_d = fscr_pkg::OP_PROGRAM;
            end else if (goErase || goResErase) begin
               opState_d = fscr_pkg::OP_ERASE;
            end else if (goPpe) begin
               opState_d = fscr_pkg::OP_PPE_WRITE;
            end
         end
         fscr_pkg::OP_PROGRAM, fscr_pkg::OP_ERASE: begin
            if (engineDone || goSusp) begin
               opState_d = fscr_pkg::OP_IDLE;
            end
         end
         fscr_pkg::OP_PPE_WRITE: begin
            if (ppeDone) begin
               opState_d = fscr_pkg::OP_IDLE;
            end
         end
         default: begin
            opState_d = fscr_pkg::OP_IDLE;
         end
      endcase
   end

   // Latch: a set in the same cycle as a clear wins.
   wire welClr = opDone || (accept && (isWrdi || isRst || isWrsr ||
      isWbpr || isLbpr || isSusp)); // [R2]
   assign write_enable_latch_d = (accept && isWren) ||
      (write_enable_latch_q && !welClr); // [R2]

   // Suspend flags follow suspend and resume of their operation.
   assign erase_suspended_flag_d = (goSusp && inErase) ||
      (erase_suspended_flag_q && !goResErase); // [R4]
   assign program_suspended_flag_d = (goSusp && inProg) ||
      (program_suspended_flag_q && !goResProg); // [R5]

   // Sequencer, latches and suspend flags.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         opState_q <= fscr_pkg::OP_IDLE;
         write_enable_latch_q <= 1'b0;
         erase_suspended_flag_q <= 1'b0;
         program_suspended_flag_q <= 1'b0;
      end else begin
         opState_q <= opState_d;
         write_enable_latch_q <= write_enable_latch_d;
         erase_suspended_flag_q <= erase_suspended_flag_d;
         program_suspended_flag_q <= program_suspended_flag_d;
      end
   end

   // Sticky lock flags; power-up restores the non-volatile ones.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         protection_lockdown_flag_q <= 1'b0; // [R6]
         secLocked_q <= nvSecLocked; // [R7]
         permLocked_q <= nvPermLocked; // [R13]
      end else begin
         if (accept && isLbpr) begin
            protection_lockdown_flag_q <= 1'b1; // [R6]
         end
         if (accept && isLsid) begin
            secLocked_q <= 1'b1; // [R7]
         end
         if (accept && isPerm && cmdData != 16'h0000) begin
            permLocked_q <= 1'b1; // [R13]
         end
      end
   end

   // Config bits; only bits 1 and 7 are writable, the rest ignored.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pin_function_select_q <= fscr_pkg::CFG_PIN_FUNCTION_RESET;
         protect_pin_enable_q <= nvProtectPinEnable; // [R14]
         ppePending_q <= 1'b0;
      end else begin
         if (goWrsr) begin
            pin_function_select_q <=
               newCfg[fscr_pkg::CFG_PIN_FUNCTION]; // [R10] [R19]
         end
         if (goPpe) begin
            ppePending_q <= newCfg[fscr_pkg::CFG_PROTECT_PIN_EN];
         end
         if (ppeDone) begin
            protect_pin_enable_q <= ppePending_q; // [R14] [R16]
         end
      end
   end

   // Self-timed enable-write counter.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ppeCnt_q <= CNT_ZERO;
      end else if (goPpe) begin
         ppeCnt_q <= PPE_LOAD; // [R16]
      end else if (ppeCnt_q != CNT_ZERO) begin
         ppeCnt_q <= ppeCnt_q - 1'b1;
      end
   end

   // Registered command outcome and side-effect pulses.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         accepted_q <= 1'b0;
         rejected_q <= 1'b0;
         start_q <= 1'b0;
         suspend_q <= 1'b0;
         resume_q <= 1'b0;
         bpr_q <= 1'b0;
         perm_q <= 1'b0;
         nvw_q <= 1'b0;
      end else begin
         accepted_q <= accept;
         rejected_q <= cmdValid && reject; // [R3] [R11]
         start_q <= goProg || goErase;
         suspend_q <= goSusp;
         resume_q <= goResProg || goResErase;
         bpr_q <= accept && isWbpr;
         perm_q <= accept && isPerm;
         nvw_q <= goPpe;
      end
   end

   // Register images; status has no write path at all.
   assign flash_status = {busy, 1'b0, secLocked_q,
      protection_lockdown_flag_q, program_suspended_flag_q,
      erase_suspended_flag_q, write_enable_latch_q,
      busy}; // [R1] [R8] [R9]
   assign flash_configuration = {protect_pin_enable_q, 3'b000,
      !permLocked_q, 1'b0, pin_function_select_q, 1'b0}; // [R13] [R19]

   // Outputs.
   assign engineStart = start_q;
   assign engineSuspend = suspend_q;
   assign engineResume = resume_q;
   assign nvPpeWrite = nvw_q;
   assign nvPpeValue = protect_pin_enable_q;
   assign bprWrite = bpr_q;
   assign permLockWrite = perm_q;
   assign protectPinsActive = !pinFuncEff && !quadMode; // [R10]
   assign quadLinesActive = pinFuncEff || quadMode; // [R10]
   assign hwWriteProtect = hwProtect;
   assign cmdAccepted = accepted_q;
   assign cmdRejected = rejected_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   wel_reject_a: assert property (cmdValid && needsWel && // [R3]
      !write_enable_latch_q |=> cmdRejected && !engineStart)
      else $error("Command taken without write enable latch.");

   wel_clear_a: assert property (cmdValid && isWrdi && !engineDone // [R2]
      |=> !flash_status[fscr_pkg::ST_WEL])
      else $error("Write disable left the latch set.");

   busy_mirror_a: assert property (flash_status[0] == // [R1]
      flash_status[7] && flash_status[6] == 1'b0)
      else $error("Busy mirror or reserved status bit wrong.");

   ppe_busy_a: assert property (goPpe |=> busy [*8]) // [R16]
      else $error("Enable write did not hold busy.");

   erase_susp_a: assert property (goSusp && inErase |=> // [R4]
      flash_status[2] && !flash_status[0] && $rose(engineSuspend))
      else $error("Erase suspend not reported.");

   prog_susp_a: assert property (goSusp && inProg |=> // [R5]
      flash_status[3] && !flash_status[2] && !flash_status[0] &&
      $rose(engineSuspend))
      else $error("Program suspend not reported.");

   lockdown_hold_a: assert property ($rose(flash_status[4]) |-> // [R6]
      flash_status[4] [*8])
      else $error("Lock-down flag dropped without power cycle.");

   sec_hold_a: assert property (flash_status[5] |=> // [R7]
      flash_status[5])
      else $error("Security lock flag was cleared.");

   quad_invalid_a: assert property (cmdValid && isQuad && // [R11]
      !flash_configuration[1] && !quadMode |=> cmdRejected)
      else $error("Quad command accepted with pin function clear.");

   hw_protect_a: assert property (cmdValid && isWrsr && hwProtect // [R17]
      |=> cmdRejected && $stable(flash_configuration))
      else $error("Config written under hardware protection.");

   // A finished array operation drops busy at the next edge.
   busy_done_a: assert property (opDone |=> // [R1]
      !flash_status[0] && !flash_status[7])
      else $error("Busy stayed set after the operation ended.");

   // A nonzero permanent-lock write clears the no-lock flag for good.
   perm_lock_a: assert property (accept && isPerm && // [R13]
      cmdData != 16'h0000 |=> !flash_configuration[3])
      else $error("Permanent lock not reported in config.");

   // Pin function set means the protect pin is never honoured.
   pin_priority_a: assert property (pin_function_select_q |-> // [R18]
      !hwWriteProtect)
      else $error("Protect pin honoured with pin function set.");

   // The timed enable write lands the pending value when it ends.
   ppe_land_a: assert property (ppeDone |=> // [R14]
      flash_configuration[7] == $past(ppePending_q))
      else $error("Enable write did not land its value.");

endmodule : fscr_regs
`default_nettype wire

// File: fscr_pkg.sv
// Constants, command kinds and states for the flash status/config registers.
// Operation
// [R1] Busy at status bits 0 and 7.
// [R2] Write-enable latch at bit 1, cleared on events.
// [R3] Latch clear rejects program, erase, protection, lock-down.
// [R4] Erase suspend flag at bit 2 until resume.
// [R5] Program suspend flag at bit 3 until resume.
// [R6] Lock-down flag at bit 4, power cycle clears.
// [R7] Security locked flag at bit 5, permanent.
// [R8] Status bit 6 reads zero.
// [R9] Status read-only and readable while busy.
// [R10] Config bit 1 selects protect pins or quad lines.
// [R11] Quad commands invalid unless pin function set.
// [R12] Pin function ignored in four-bit command mode.
// [R13] Config bit 3 clears forever after permanent lock.
// [R14] Config bit 7 protect-pin enable, non-volatile.
// [R15] Hardware protect needs pin low and enable set.
// [R16] Enable write is self-timed, busy meanwhile.
// [R17] Hardware protect blocks protection and config writes.
// [R18] Pin function overrides the protect-pin enable.
// [R19] Reserved config bits read zero, writes ignored.
package fscr_pkg;

   // Clock and self-timed enable-write duration.
   localparam int CLK_PERIOD_NS = 100;
   localparam int PROTECT_ENABLE_WRITE_TIME_NS = 10000;
   localparam int PPE_WRITE_CYCLES =
      (PROTECT_ENABLE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Status register field positions.
   localparam int ST_BUSY = 0;
   localparam int ST_WEL = 1;
   localparam int ST_ERASE_SUSP = 2;
   localparam int ST_PROG_SUSP = 3;
   localparam int ST_LOCKDOWN = 4;
   localparam int ST_SEC_LOCKED = 5;
   localparam int ST_RESERVED = 6;
   localparam int ST_BUSY_MIRROR = 7;

   // Configuration register field positions and reset values.
   localparam int CFG_PIN_FUNCTION = 1;
   localparam int CFG_NO_PERM_LOCK = 3;
   localparam int CFG_PROTECT_PIN_EN = 7;
   localparam logic CFG_PIN_FUNCTION_RESET = 1'b0;
   localparam logic [7:0] REG_ZERO = 8'h00;

   // The write-status command carries the config byte in its upper byte.
   localparam int WRSR_CFG_LSB = 8;

   // Decoded command kinds from the instruction decoder.
   typedef enum logic [4:0] {
      CMD_NOP = 5'h00,
      CMD_WRITE_ENABLE = 5'h01,
      CMD_WRITE_DISABLE = 5'h02,
      CMD_WRITE_STATUS = 5'h03,
      CMD_PAGE_PROGRAM = 5'h04,
      CMD_QUAD_PAGE_PROGRAM = 5'h05,
      CMD_ERASE = 5'h06,
      CMD_WRITE_BLOCK_PROTECT = 5'h07,
      CMD_LOCKDOWN_BLOCK_PROTECT = 5'h08,
      CMD_WRITE_PERMANENT_LOCK = 5'h09,
      CMD_PROGRAM_SECURITY = 5'h0A,
      CMD_LOCKOUT_SECURITY = 5'h0B,
      CMD_SUSPEND = 5'h0C,
      CMD_RESUME = 5'h0D,
      CMD_RESET = 5'h0E,
      CMD_QUAD_OUTPUT_READ = 5'h0F,
      CMD_QUAD_IO_READ = 5'h10,
      CMD_WRAPPED_BURST_READ = 5'h11,
      CMD_OTHER_READ = 5'h12
   } fscr_cmd_t;

   // Internal operation states, one-hot.
   typedef enum logic [3:0] {
      OP_IDLE = 4'h1,
      OP_PROGRAM = 4'h2,
      OP_ERASE = 4'h4,
      OP_PPE_WRITE = 4'h8
   } fscr_op_t;

endpackage : fscr_pkg

// File: fscr_engine_model.sv
// Array engine model that finishes each operation after a fixed delay.
`timescale 1ns/10ps
`default_nettype none
module fscr_engine_model #(
   parameter int DLY = 5
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Handshake with the register block.
   input wire logic start,
   input wire logic suspend,
   input wire logic resume,
   output logic done
);
   int cnt;

   // Start or resume loads the full delay, and suspend clears the count.
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (!resetn || suspend) begin
         cnt <= 0;
      end else if (start || resume) begin
         cnt <= DLY;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         done <= (cnt == 1);
      end
   end
endmodule : fscr_engine_model
`default_nettype wire

// File: flash_status_config_regs_tb.sv
// Self-checking bench for the flash status and configuration registers.
`timescale 1ns/10ps
`default_nettype none
module flash_status_config_regs_tb;
   logic clk, resetn, cmdValid, quadMode, engineDone, writeProtectN;
   logic nvPpe, nvPerm, nvSec, eStart, eSusp, eRes;
   logic hwWp, pinsOn, quadOn, acc, rej, ppeVal;
   logic bprW, permW, nvW;
   fscr_pkg::fscr_cmd_t cmdKind;
   logic [15:0] cmdData;
   logic [7:0] flash_status, flash_configuration;
   int err_count = 0;
   int n_checks = 0;

   // Device under test with a short protect-enable write time.
   fscr_regs #(.PPE_CYCLES(8)) u_dut (
      .clk(clk), .resetn(resetn), .cmdValid(cmdValid), .cmdKind(cmdKind),
      .cmdData(cmdData), .quadMode(quadMode), .engineDone(engineDone),
      .engineStart(eStart), .engineSuspend(eSusp), .engineResume(eRes),
      .writeProtectN(writeProtectN), .nvProtectPinEnable(nvPpe),
      .nvPermLocked(nvPerm), .nvSecLocked(nvSec), .nvPpeWrite(nvW),
      .nvPpeValue(ppeVal), .bprWrite(bprW), .permLockWrite(permW),
      .protectPinsActive(pinsOn), .quadLinesActive(quadOn),
      .hwWriteProtect(hwWp), .flash_status(flash_status),
      .flash_configuration(flash_configuration), .cmdAccepted(acc),
      .cmdRejected(rej));

   // Array engine on the far side of the handshake.
   fscr_engine_model #(.DLY(5)) u_eng (
      .clk(clk), .resetn(resetn), .start(eStart), .suspend(eSusp),
      .resume(eRes), .done(engineDone));

   // Clock of 100 ns period.
   always #50 clk = ~clk;

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk

   // One command pulse; accept and reject are looked at in the answer cycle.
   task automatic cmd(input fscr_pkg::fscr_cmd_t k, input logic [15:0] d,
                      input logic a);
      @(negedge clk);
      cmdValid = 1'b1;
      cmdKind = k;
      cmdData = d;
      @(negedge clk);
      cmdValid = 1'b0;
      chk({6'h00, acc, rej}, {6'h00, a, !a});
   endtask : cmd

   task automatic wren();
      cmd(fscr_pkg::CMD_WRITE_ENABLE, 16'h0000, 1'b1);
   endtask : wren

   // Polls busy with a bound; a hang ends the run.
   task automatic idle();
      for (int i = 0; i < 60; i++) begin
         @(negedge clk);
         if (flash_status[0] === 1'b0) begin
            return;
         end
      end
      err_count++;
      $display("CHECK FAILED at %0t: busy never cleared", $time);
      end_of_test();
   endtask : idle

   task automatic power_up(input logic s, input logic p, input logic w);
      nvSec = s;
      nvPerm = p;
      nvPpe = w;
      resetn = 1'b0;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
   endtask : power_up

   task automatic pin(input logic wp, input logic [7:0] e);
      writeProtectN = wp;
      #1;
      chk({7'h00, hwWp}, e);
   endtask : pin

   initial begin
      clk = 1'b0;
      cmdValid = 1'b0;
      cmdKind = fscr_pkg::CMD_NOP;
      cmdData = 16'h0000;
      quadMode = 1'b0;
      writeProtectN = 1'b1;
      power_up(1'b0, 1'b0, 1'b0);
      chk(flash_status, 8'h00);
      chk(flash_configuration, 8'h08);
      $display("Test reset done");
      cmd(fscr_pkg::CMD_PAGE_PROGRAM, 16'h0000, 1'b0);
      cmd(fscr_pkg::CMD_ERASE, 16'h0000, 1'b0);
      cmd(fscr_pkg::CMD_WRITE_BLOCK_PROTECT, 16'h0000, 1'b0);
      cmd(fscr_pkg::CMD_LOCKDOWN_BLOCK_PROTECT, 16'h0000, 1'b0);
      wren();
      chk(flash_status, 8'h02);
      cmd(fscr_pkg::CMD_PAGE_PROGRAM, 16'h0000, 1'b1);
      chk(flash_status, 8'h83);
      idle();
      chk(flash_status, 8'h00);
      $display("Test program done");
      wren();
      cmd(fscr_pkg::CMD_ERASE, 16'h0000, 1'b1);
      cmd(fscr_pkg::CMD_SUSPEND, 16'h0000, 1'b1);
      chk(flash_status, 8'h04);
      cmd(fscr_pkg::CMD_RESUME, 16'h0000, 1'b1);
      chk(flash_status, 8'h81);
      idle();
      wren();
      cmd(fscr_pkg::CMD_PAGE_PROGRAM, 16'h0000, 1'b1);
      cmd(fscr_pkg::CMD_SUSPEND, 16'h0000, 1'b1);
      chk(flash_status, 8'h08);
      cmd(fscr_pkg::CMD_RESUME, 16'h0000, 1'b1);
      chk(flash_status, 8'h81);
      idle();
      wren();
      cmd(fscr_pkg::CMD_WRITE_DISABLE, 16'h0000, 1'b1);
      chk(flash_status, 8'h00);
      $display("Test suspend done");
      cmd(fscr_pkg::CMD_QUAD_OUTPUT_READ, 16'h0000, 1'b0);
      wren();
      cmd(fscr_pkg::CMD_QUAD_PAGE_PROGRAM, 16'h0000, 1'b0);
      cmd(fscr_pkg::CMD_RESET, 16'h0000, 1'b1);
      chk(flash_status, 8'h00);
      quadMode = 1'b1;
      cmd(fscr_pkg::CMD_QUAD_OUTPUT_READ, 16'h0000, 1'b1);
      quadMode = 1'b0;
      wren();
      cmd(fscr_pkg::CMD_WRITE_STATUS, 16'h7700, 1'b1);
      chk(flash_configuration, 8'h0A);
      chk(flash_status, 8'h00);
      cmd(fscr_pkg::CMD_QUAD_OUTPUT_READ, 16'h0000, 1'b1);
      cmd(fscr_pkg::CMD_QUAD_IO_READ, 16'h0000, 1'b1);
      cmd(fscr_pkg::CMD_WRAPPED_BURST_READ, 16'h0000, 1'b1);
      chk({6'h00, quadOn, pinsOn}, 8'h02);
      wren();
      cmd(fscr_pkg::CMD_WRITE_PERMANENT_LOCK, 16'h0001, 1'b1);
      chk({7'h00, permW}, 8'h01);
      chk(flash_configuration, 8'h02);
      $display("Test quad done");
      wren();
      cmd(fscr_pkg::CMD_WRITE_STATUS, 16'h8000, 1'b1);
      chk({7'h00, nvW}, 8'h01);
      chk(flash_status, 8'h81);
      idle();
      chk(flash_configuration, 8'h80);
      chk({7'h00, ppeVal}, 8'h01);
      pin(1'b0, 8'h01);
      wren();
      cmd(fscr_pkg::CMD_WRITE_BLOCK_PROTECT, 16'h0000, 1'b0);
      cmd(fscr_pkg::CMD_WRITE_STATUS, 16'h0000, 1'b0);
      wren();
      cmd(fscr_pkg::CMD_PAGE_PROGRAM, 16'h0000, 1'b1);
      idle();
      pin(1'b1, 8'h00);
      wren();
      cmd(fscr_pkg::CMD_WRITE_STATUS, 16'h8200, 1'b1);
      chk(flash_configuration, 8'h82);
      pin(1'b0, 8'h00);
      wren();
      cmd(fscr_pkg::CMD_WRITE_BLOCK_PROTECT, 16'h0000, 1'b1);
      chk({7'h00, bprW}, 8'h01);
      $display("Test protect pin done");
      wren();
      cmd(fscr_pkg::CMD_LOCKDOWN_BLOCK_PROTECT, 16'h0000, 1'b1);
      chk(flash_status, 8'h10);
      wren();
      cmd(fscr_pkg::CMD_WRITE_BLOCK_PROTECT, 16'h0000, 1'b0);
      cmd(fscr_pkg::CMD_WRITE_PERMANENT_LOCK, 16'h0001, 1'b0);
      wren();
      cmd(fscr_pkg::CMD_LOCKOUT_SECURITY, 16'h0000, 1'b1);
      chk(flash_status, 8'hB3);
      idle();
      chk(flash_status, 8'h30);
      wren();
      cmd(fscr_pkg::CMD_LOCKOUT_SECURITY, 16'h0000, 1'b0);
      power_up(1'b1, 1'b1, 1'b1);
      chk(flash_status, 8'h20);
      chk(flash_configuration, 8'h80);
      $display("Test locks done");
      end_of_test();
   end
endmodule : flash_status_config_regs_tb
`default_nettype wire
